// ===== verilog/ipe_irq_prio_mask.sv
// Module: interrupt priority register, extended mask register and arbitration
// Behaviour
// - Priority bit 7 reads one, writes ignored.
// - Priority bit 6 raises SPI to high.
// - Priority bit 5 raises timer 2 to high.
// - Priority bit 4 raises UART to high.
// - Priority bit 3 low keeps timer 1 low.
// - Priority bit 2 raises external interrupt 1.
// - Priority bit 1 raises timer 0 to high.
// - Priority bit 0 raises external interrupt 0.
// - Priority register has bit set and clear.
// - Mask bit 7 gates both timer 3 flags.
// - Mask bit 5 gates both comparator flags.
// - Mask bit 4 gates capture array requests.
// - Mask bit 3 gates ADC conversion done.
// - Mask bit 2 gates ADC window compare.
// - Mask bit 1 gates port match events.
// - Mask bit 0 gates two-wire bus requests.
// - Global gate low blocks every source.
`timescale 1ns/1ps
module ipe_irq_prio_mask
  import ipe_pkg::*;
(
  input  wire logic                    REF_CLK,
  input  wire logic                    RESET_N,
  input  wire ipe_sfr_req_t            SFR_REQ,
  output logic [7:0]                   SFR_RDATA,
  output logic                         SFR_RVALID,
  input  wire logic                    GLOBAL_IRQ_GATE,
  input  wire logic [IPE_NUM_LEG-1:0]  LEGACY_PEND,
  input  wire logic [IPE_NUM_LEG-1:0]  LEGACY_EN,
  input  wire ipe_ext_flags_t          EXT_FLAGS,
  input  wire logic [7:0]              EXT_PRIO_HIGH,
  input  wire logic                    IRQ_ACK,
  input  wire logic                    IRQ_RETI,
  output logic                         IRQ_REQ,
  output ipe_irq_sel_t                 IRQ_SEL,
  output ipe_svc_t                     SVC_STATE
);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  logic [6:0]             prio_reg;
  logic [7:0]             emask_reg;
  logic [7:0]             prio_view;
  logic [7:0]             rdata_reg;
  logic                   rvalid_reg;
  logic                   hit_prio;
  logic                   hit_emask;
  logic [IPE_NUM_SRC-1:0] src_pend;
  logic [IPE_NUM_SRC-1:0] src_en;
  logic [IPE_NUM_SRC-1:0] src_high;
  logic [IPE_NUM_SRC-1:0] live_req;
  logic [IPE_NUM_SRC-1:0] high_req;
  logic [IPE_NUM_SRC-1:0] low_req;
  logic                   high_found;
  logic                   low_found;
  logic [3:0]             high_index;
  logic [3:0]             low_index;
  logic                   high_allowed;
  logic                   low_allowed;
  logic                   cand_valid;
  ipe_irq_sel_t           cand_sel;
  logic                   irq_req_reg;
  ipe_irq_sel_t           irq_sel_reg;
  ipe_svc_t               svc_reg;
  ipe_svc_t               svc_next;
  logic                   ack_taken;

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  assign hit_prio  = (SFR_REQ.addr == IPE_PRIO_ADDR);
  assign hit_emask = (SFR_REQ.addr == IPE_EMASK_ADDR);

  // Bit 7 is not stored and always reads as one
  assign prio_view = {IPE_PRIO_RESET[IPE_P_UNUSED], prio_reg};

  // ---------------------------------------------------------------------------
  // Priority register
  // ---------------------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      prio_reg <= IPE_PRIO_RESET[6:0];
    end else if (hit_prio && SFR_REQ.wr) begin
      // Whole-byte write drops bit 7
      prio_reg <= SFR_REQ.wdata[6:0];
    end else if (hit_prio && SFR_REQ.bit_sel != 3'(IPE_P_UNUSED)) begin
      // Single-bit operations, bit 7 ignored
      if (SFR_REQ.bit_set) begin
        prio_reg[SFR_REQ.bit_sel] <= 1'b1;
      end else if (SFR_REQ.bit_clr) begin
        prio_reg[SFR_REQ.bit_sel] <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Extended mask register
  // ---------------------------------------------------------------------------
  // Bit 6 is stored as written and steers nothing; software keeps it zero
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      emask_reg <= IPE_EMASK_RESET;
    end else if (hit_emask && SFR_REQ.wr) begin
      emask_reg <= SFR_REQ.wdata;
    end
  end

  // ---------------------------------------------------------------------------
  // Read path, one cycle after the read strobe
  // ---------------------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      rdata_reg  <= IPE_UNMAPPED_RD;
      rvalid_reg <= 1'b0;
    end else if (SFR_REQ.rd && hit_prio) begin
      rdata_reg  <= prio_view;
      rvalid_reg <= 1'b1;
    end else if (SFR_REQ.rd && hit_emask) begin
      rdata_reg  <= emask_reg;
      rvalid_reg <= 1'b1;
    end else begin
      rdata_reg  <= IPE_UNMAPPED_RD;
      rvalid_reg <= 1'b0;
    end
  end

  assign SFR_RDATA  = rdata_reg;
  assign SFR_RVALID = rvalid_reg;

  // ---------------------------------------------------------------------------
  // Legacy sources: pending, enable and priority level
  // ---------------------------------------------------------------------------
  assign src_pend[IPE_NUM_LEG-1:0] = LEGACY_PEND;
  assign src_en[IPE_NUM_LEG-1:0]   = LEGACY_EN;

  assign src_high[IPE_P_EXT0] = prio_reg[IPE_P_EXT0];
  assign src_high[IPE_P_TMR0] = prio_reg[IPE_P_TMR0];
  assign src_high[IPE_P_EXT1] = prio_reg[IPE_P_EXT1];
  // Timer 1 follows its bit like every other legacy source
  assign src_high[IPE_P_TMR1] = prio_reg[IPE_P_TMR1];
  assign src_high[IPE_P_UART] = prio_reg[IPE_P_UART];
  assign src_high[IPE_P_TMR2] = prio_reg[IPE_P_TMR2];
  assign src_high[IPE_P_SPI]  = prio_reg[IPE_P_SPI];

  // ---------------------------------------------------------------------------
  // Extended sources: pending flags
  // ---------------------------------------------------------------------------
  assign src_pend[IPE_S_TWOWIRE] = EXT_FLAGS.twowire_req;
  assign src_pend[IPE_S_PMATCH]  = EXT_FLAGS.port_match_req;
  assign src_pend[IPE_S_ADCWIN]  = EXT_FLAGS.adc_window_flag;
  assign src_pend[IPE_S_ADCDONE] = EXT_FLAGS.adc_done_flag;
  assign src_pend[IPE_S_CAPARR]  = EXT_FLAGS.capture_array_req;
  assign src_pend[IPE_S_COMP]    = EXT_FLAGS.comparator_rise_flag
                                 | EXT_FLAGS.comparator_fall_flag;
  assign src_pend[IPE_S_RSVD]    = 1'b0;
  assign src_pend[IPE_S_TMR3]    = EXT_FLAGS.timer3_low_overflow_flag
                                 | EXT_FLAGS.timer3_high_overflow_flag;

  // ---------------------------------------------------------------------------
  // Extended sources: masks
  // ---------------------------------------------------------------------------
  assign src_en[IPE_S_TWOWIRE] = emask_reg[IPE_M_TWOWIRE];
  assign src_en[IPE_S_PMATCH]  = emask_reg[IPE_M_PMATCH];
  assign src_en[IPE_S_ADCWIN]  = emask_reg[IPE_M_ADCWIN];
  assign src_en[IPE_S_ADCDONE] = emask_reg[IPE_M_ADCDONE];
  assign src_en[IPE_S_CAPARR]  = emask_reg[IPE_M_CAPARR];
  assign src_en[IPE_S_COMP]    = emask_reg[IPE_M_COMP];
  assign src_en[IPE_S_RSVD]    = 1'b0;
  assign src_en[IPE_S_TMR3]    = emask_reg[IPE_M_TMR3];

  // ---------------------------------------------------------------------------
  // Extended sources: levels come from the external priority register
  // ---------------------------------------------------------------------------
  assign src_high[IPE_S_TWOWIRE] = EXT_PRIO_HIGH[IPE_M_TWOWIRE];
  assign src_high[IPE_S_PMATCH]  = EXT_PRIO_HIGH[IPE_M_PMATCH];
  assign src_high[IPE_S_ADCWIN]  = EXT_PRIO_HIGH[IPE_M_ADCWIN];
  assign src_high[IPE_S_ADCDONE] = EXT_PRIO_HIGH[IPE_M_ADCDONE];
  assign src_high[IPE_S_CAPARR]  = EXT_PRIO_HIGH[IPE_M_CAPARR];
  assign src_high[IPE_S_COMP]    = EXT_PRIO_HIGH[IPE_M_COMP];
  assign src_high[IPE_S_RSVD]    = 1'b0;
  assign src_high[IPE_S_TMR3]    = EXT_PRIO_HIGH[IPE_M_TMR3];

  // ---------------------------------------------------------------------------
  // Gating and split by level
  // ---------------------------------------------------------------------------
  assign live_req = src_pend & src_en & {IPE_NUM_SRC{GLOBAL_IRQ_GATE}};
  assign high_req = live_req & src_high;
  assign low_req  = live_req & ~src_high;

  ipe_pick_first u_pick_high (
    .req   (high_req),
    .found (high_found),
    .index (high_index)
  );

  ipe_pick_first u_pick_low (
    .req   (low_req),
    .found (low_found),
    .index (low_index)
  );

  // ---------------------------------------------------------------------------
  // Preemption check against the running service level
  // ---------------------------------------------------------------------------
  // High may interrupt idle or a low routine; low only an idle CPU
  assign high_allowed = (svc_reg == IPE_SVC_IDLE) || (svc_reg == IPE_SVC_LOW);
  assign low_allowed  = (svc_reg == IPE_SVC_IDLE);

  always_comb begin
    cand_valid     = 1'b0;
    cand_sel.index = 4'h0;
    cand_sel.high  = 1'b0;
    if (high_found && high_allowed) begin
      cand_valid     = 1'b1;
      cand_sel.index = high_index;
      cand_sel.high  = 1'b1;
    end else if (low_found && low_allowed) begin
      cand_valid     = 1'b1;
      cand_sel.index = low_index;
      cand_sel.high  = 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Request register toward the CPU
  // ---------------------------------------------------------------------------
  assign ack_taken = irq_req_reg && IRQ_ACK;

  // Drops for one cycle after an acknowledge so the new level is seen
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      irq_req_reg       <= 1'b0;
      irq_sel_reg.index <= 4'h0;
      irq_sel_reg.high  <= 1'b0;
    end else if (ack_taken) begin
      irq_req_reg <= 1'b0;
    end else begin
      irq_req_reg <= cand_valid;
      irq_sel_reg <= cand_sel;
    end
  end

  assign IRQ_REQ = irq_req_reg;
  assign IRQ_SEL = irq_sel_reg;

  // ---------------------------------------------------------------------------
  // Service level tracking
  // ---------------------------------------------------------------------------
  always_comb begin
    svc_next = svc_reg;
    if (ack_taken) begin
      case (svc_reg)
        IPE_SVC_IDLE: begin
          svc_next = irq_sel_reg.high ? IPE_SVC_HIGH : IPE_SVC_LOW;
        end
        IPE_SVC_LOW: begin
          svc_next = IPE_SVC_HI_O_LO;
        end
        default: begin
          svc_next = svc_reg;
        end
      endcase
    end else if (IRQ_RETI) begin
      case (svc_reg)
        IPE_SVC_LOW: begin
          svc_next = IPE_SVC_IDLE;
        end
        IPE_SVC_HIGH: begin
          svc_next = IPE_SVC_IDLE;
        end
        IPE_SVC_HI_O_LO: begin
          svc_next = IPE_SVC_LOW;
        end
        default: begin
          svc_next = IPE_SVC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      svc_reg <= IPE_SVC_IDLE;
    end else begin
      svc_reg <= svc_next;
    end
  end

  assign SVC_STATE = svc_reg;

endmodule : ipe_irq_prio_mask

// ===== inc/ipe_pkg.sv
// Package: constants and types for the interrupt priority and extended mask block
package ipe_pkg;

  // ---------------------------------------------------------------------------
  // Register addresses and reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] IPE_PRIO_ADDR   = 8'hB8;
  localparam logic [7:0] IPE_EMASK_ADDR  = 8'hE6;
  localparam logic [7:0] IPE_PRIO_RESET  = 8'h80;
  localparam logic [7:0] IPE_EMASK_RESET = 8'h00;
  localparam logic [7:0] IPE_UNMAPPED_RD = 8'h00;

  // ---------------------------------------------------------------------------
  // Field positions of the priority register
  // ---------------------------------------------------------------------------
  localparam int IPE_P_EXT0   = 0;
  localparam int IPE_P_TMR0   = 1;
  localparam int IPE_P_EXT1   = 2;
  localparam int IPE_P_TMR1   = 3;
  localparam int IPE_P_UART   = 4;
  localparam int IPE_P_TMR2   = 5;
  localparam int IPE_P_SPI    = 6;
  localparam int IPE_P_UNUSED = 7;

  // ---------------------------------------------------------------------------
  // Field positions of the extended mask register
  // ---------------------------------------------------------------------------
  localparam int IPE_M_TWOWIRE = 0;
  localparam int IPE_M_PMATCH  = 1;
  localparam int IPE_M_ADCWIN  = 2;
  localparam int IPE_M_ADCDONE = 3;
  localparam int IPE_M_CAPARR  = 4;
  localparam int IPE_M_COMP    = 5;
  localparam int IPE_M_RSVD    = 6;
  localparam int IPE_M_TMR3    = 7;

  // ---------------------------------------------------------------------------
  // Source indices, lowest index wins within a level
  // ---------------------------------------------------------------------------
  localparam int IPE_NUM_SRC   = 15;
  localparam int IPE_NUM_LEG   = 7;
  localparam int IPE_S_TWOWIRE = 7;
  localparam int IPE_S_PMATCH  = 8;
  localparam int IPE_S_ADCWIN  = 9;
  localparam int IPE_S_ADCDONE = 10;
  localparam int IPE_S_CAPARR  = 11;
  localparam int IPE_S_COMP    = 12;
  localparam int IPE_S_RSVD    = 13;
  localparam int IPE_S_TMR3    = 14;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
    logic       bit_set;
    logic       bit_clr;
    logic [2:0] bit_sel;
  } ipe_sfr_req_t;

  typedef struct packed {
    logic timer3_low_overflow_flag;
    logic timer3_high_overflow_flag;
    logic comparator_rise_flag;
    logic comparator_fall_flag;
    logic capture_array_req;
    logic adc_done_flag;
    logic adc_window_flag;
    logic port_match_req;
    logic twowire_req;
  } ipe_ext_flags_t;

  typedef struct packed {
    logic [3:0] index;
    logic       high;
  } ipe_irq_sel_t;

  typedef enum logic [1:0] {
    IPE_SVC_IDLE    = 2'b00,
    IPE_SVC_LOW     = 2'b01,
    IPE_SVC_HIGH    = 2'b10,
    IPE_SVC_HI_O_LO = 2'b11
  } ipe_svc_t;

endpackage : ipe_pkg

// ===== verilog/ipe_pick_first.sv
// Module: finds the lowest-index set bit of a request vector
`timescale 1ns/1ps
module ipe_pick_first
  import ipe_pkg::*;
(
  input  wire logic [IPE_NUM_SRC-1:0] req,
  output logic                        found,
  output logic [3:0]                  index
);

  // ---------------------------------------------------------------------------
  // Scan from the top so the lowest set bit is the last one kept
  // ---------------------------------------------------------------------------
  always_comb begin
    found = 1'b0;
    index = 4'h0;
    for (int i = IPE_NUM_SRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        found = 1'b1;
        index = 4'(i);
      end
    end
  end

endmodule : ipe_pick_first

// ===== sim/ipe_irq_prio_mask_props.sv
// Checker: concurrent properties of the priority and extended mask block
`timescale 1ns/1ps
module ipe_irq_prio_mask_props
  import ipe_pkg::*;
(
  input wire logic           REF_CLK,
  input wire logic           RESET_N,
  input wire ipe_sfr_req_t   SFR_REQ,
  input wire logic [7:0]     SFR_RDATA,
  input wire logic           SFR_RVALID,
  input wire logic           GLOBAL_IRQ_GATE,
  input wire ipe_ext_flags_t EXT_FLAGS,
  input wire logic           IRQ_ACK,
  input wire logic           IRQ_REQ,
  input wire ipe_irq_sel_t   IRQ_SEL,
  input wire ipe_svc_t       SVC_STATE
);
  default clocking dc @(posedge REF_CLK);
  endclocking
  default disable iff (!RESET_N);

  a_prio_top_one: assert property (SFR_RVALID && $past(SFR_REQ.addr) == IPE_PRIO_ADDR
    |-> SFR_RDATA[7]) else $error("priority top bit read back low");
  a_read_answer: assert property (SFR_REQ.rd && (SFR_REQ.addr == IPE_PRIO_ADDR
    || SFR_REQ.addr == IPE_EMASK_ADDR) |=> SFR_RVALID) else $error("mapped read not answered");
  a_gate_blocks: assert property (!GLOBAL_IRQ_GATE |=> !IRQ_REQ)
    else $error("request with global gate low");
  a_ack_drops: assert property (IRQ_ACK && IRQ_REQ |=> !IRQ_REQ && SVC_STATE != IPE_SVC_IDLE)
    else $error("acknowledge not taken");
  a_low_enters: assert property (IRQ_ACK && IRQ_REQ && !IRQ_SEL.high
    |=> SVC_STATE == IPE_SVC_LOW) else $error("low service not entered");
  a_high_nests: assert property (IRQ_ACK && IRQ_REQ && IRQ_SEL.high && SVC_STATE == IPE_SVC_LOW
    |=> SVC_STATE == IPE_SVC_HI_O_LO) else $error("high did not nest over low");
  a_high_blocks: assert property ($past(SVC_STATE == IPE_SVC_HIGH
    || SVC_STATE == IPE_SVC_HI_O_LO) |-> !IRQ_REQ)
    else $error("request during high service");
  a_low_waits: assert property (IRQ_REQ && $past(SVC_STATE) == IPE_SVC_LOW |-> IRQ_SEL.high)
    else $error("low request during low service");
  a_timer3_src: assert property (IRQ_REQ && IRQ_SEL.index == 4'hE
    |-> $past(EXT_FLAGS.timer3_low_overflow_flag || EXT_FLAGS.timer3_high_overflow_flag))
    else $error("timer 3 request without flag");
endmodule : ipe_irq_prio_mask_props

bind ipe_irq_prio_mask ipe_irq_prio_mask_props i_ipe_irq_prio_mask_props (
  .REF_CLK(REF_CLK), .RESET_N(RESET_N), .SFR_REQ(SFR_REQ), .SFR_RDATA(SFR_RDATA),
  .SFR_RVALID(SFR_RVALID), .GLOBAL_IRQ_GATE(GLOBAL_IRQ_GATE), .EXT_FLAGS(EXT_FLAGS),
  .IRQ_ACK(IRQ_ACK), .IRQ_REQ(IRQ_REQ), .IRQ_SEL(IRQ_SEL), .SVC_STATE(SVC_STATE)
);

// ===== sim/ipe_cpu_model.sv
// Partner: CPU core model for register accesses and interrupt handshakes
`timescale 1ns/1ps
module ipe_cpu_model
  import ipe_pkg::*;
(
  input  wire logic       clk,
  output ipe_sfr_req_t    sfr_req,
  output logic            irq_ack,
  output logic            irq_reti,
  input  wire logic [7:0] sfr_rdata,
  input  wire logic       sfr_rvalid
);
  initial begin
    sfr_req  = '0;
    irq_ack  = 1'b0;
    irq_reti = 1'b0;
  end

  // One-cycle strobe; the answer is picked up a cycle later
  task automatic op(input ipe_sfr_req_t q, output logic [7:0] dat, output logic val);
    @(negedge clk);
    sfr_req = q;
    @(negedge clk);
    sfr_req = '0;
    dat = sfr_rdata;
    val = sfr_rvalid;
  endtask : op

  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    ipe_sfr_req_t q;
    logic [7:0]   dat;
    logic         val;
    q = '0;
    q.addr = a;
    q.wr = 1'b1;
    q.wdata = w;
    if (a == IPE_EMASK_ADDR) q.wdata[6] = 1'b0;
    op(q, dat, val);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] dat, output logic val);
    ipe_sfr_req_t q;
    q = '0;
    q.addr = a;
    q.rd = 1'b1;
    op(q, dat, val);
  endtask : rd

  task automatic bop(input logic [2:0] sel, input logic set);
    ipe_sfr_req_t q;
    logic [7:0]   dat;
    logic         val;
    q = '0;
    q.addr = IPE_PRIO_ADDR;
    q.bit_set = set;
    q.bit_clr = !set;
    q.bit_sel = sel;
    op(q, dat, val);
  endtask : bop

  // Acknowledge or return pulse, optionally after a delay
  task automatic hs(input logic is_ack, input int slow);
    repeat (slow) @(negedge clk);
    @(negedge clk);
    irq_ack  = is_ack;
    irq_reti = !is_ack;
    @(negedge clk);
    irq_ack  = 1'b0;
    irq_reti = 1'b0;
  endtask : hs
endmodule : ipe_cpu_model

// ===== sim/tb_top.sv
// Testbench: register, masking and preemption checks against a CPU model
`timescale 1ns/1ps
module tb_top
  import ipe_pkg::*;
;
  logic           ref_clk = 1'b0;
  logic           reset_n = 1'b0;
  ipe_sfr_req_t   sfr_req;
  logic [7:0]     sfr_rdata;
  logic           sfr_rvalid;
  logic           gate = 1'b0;
  logic [6:0]     pend = 7'h00;
  logic [6:0]     en = 7'h00;
  ipe_ext_flags_t flags = '0;
  logic [7:0]     ext_hi = 8'h00;
  logic           ack;
  logic           reti;
  logic           irq_req;
  ipe_irq_sel_t   irq_sel;
  ipe_svc_t       svc;
  logic [8:0]     irq_seen;
  logic [7:0]     prio_e = 8'h80;
  logic [7:0]     mask_e = 8'h00;
  logic [7:0]     d;
  logic           v;
  logic [31:0]    r;
  int             seed = 32'hB2E9EB5C;
  int             fails = 0;
  int             num_checks = 0;

  always #25 ref_clk = ~ref_clk;
  assign irq_seen = {3'h0, irq_req, irq_sel & {5{irq_req}}};

  ipe_irq_prio_mask i_ipe_irq_prio_mask (
    .REF_CLK(ref_clk), .RESET_N(reset_n), .SFR_REQ(sfr_req), .SFR_RDATA(sfr_rdata),
    .SFR_RVALID(sfr_rvalid), .GLOBAL_IRQ_GATE(gate), .LEGACY_PEND(pend), .LEGACY_EN(en),
    .EXT_FLAGS(flags), .EXT_PRIO_HIGH(ext_hi), .IRQ_ACK(ack), .IRQ_RETI(reti),
    .IRQ_REQ(irq_req), .IRQ_SEL(irq_sel), .SVC_STATE(svc)
  );
  ipe_cpu_model i_ipe_cpu_model (
    .clk(ref_clk), .sfr_req(sfr_req), .irq_ack(ack), .irq_reti(reti),
    .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid)
  );

  // ----
  // Expectation and reporting
  // ----
  function automatic logic [8:0] exp_irq;
    logic [14:0] live;
    logic [14:0] hi;
    exp_irq = 9'h000;
    live[6:0] = pend & en;
    live[7] = flags.twowire_req & mask_e[0];
    live[8] = flags.port_match_req & mask_e[1];
    live[9] = flags.adc_window_flag & mask_e[2];
    live[10] = flags.adc_done_flag & mask_e[3];
    live[11] = flags.capture_array_req & mask_e[4];
    live[12] = (flags.comparator_rise_flag | flags.comparator_fall_flag) & mask_e[5];
    live[13] = 1'b0;
    live[14] = (flags.timer3_low_overflow_flag | flags.timer3_high_overflow_flag) & mask_e[7];
    live = live & {15{gate}};
    hi = {ext_hi, prio_e[6:0]};
    for (int i = 14; i >= 0; i--)
      if (live[i] && !hi[i]) exp_irq = {4'h1, i[3:0], 1'b0};
    for (int i = 14; i >= 0; i--)
      if (live[i] && hi[i]) exp_irq = {4'h1, i[3:0], 1'b1};
  endfunction : exp_irq

  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic settle;
    repeat (2) @(negedge ref_clk);
  endtask : settle

  task automatic tally_and_finish;
    if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (100000) @(posedge ref_clk);
    fails++;
    tally_and_finish();
  end

  // ----
  // Main sequence
  // ----
  initial begin
    repeat (16) @(negedge ref_clk);
    reset_n = 1'b1;
    i_ipe_cpu_model.rd(IPE_PRIO_ADDR, d, v);
    chk({v, d}, {1'b1, IPE_PRIO_RESET});
    i_ipe_cpu_model.rd(IPE_EMASK_ADDR, d, v);
    chk({v, d}, {1'b1, IPE_EMASK_RESET});
    i_ipe_cpu_model.rd(8'h55, d, v);
    chk({v, d}, 9'h000);
    for (int n = 0; n < 24; n++) begin
      r = $random(seed);
      i_ipe_cpu_model.bop(r[2:0], r[3]);
      if (r[2:0] != 3'h7) prio_e[r[2:0]] = r[3];
      i_ipe_cpu_model.rd(IPE_PRIO_ADDR, d, v);
      chk({v, d}, {1'b1, prio_e});
    end
    gate = 1'b1;
    en = 7'h7F;
    pend = 7'h7F;
    for (int b = 0; b < 7; b++) begin
      i_ipe_cpu_model.wr(IPE_PRIO_ADDR, 8'h01 << b);
      prio_e = 8'h80 | (8'h01 << b);
      settle();
      chk(irq_seen, {4'h1, 4'(b), 1'b1});
    end
    i_ipe_cpu_model.wr(IPE_PRIO_ADDR, 8'h00);
    pend = 7'h08;
    settle();
    chk(irq_seen, 9'h026);
    i_ipe_cpu_model.wr(IPE_PRIO_ADDR, 8'h08);
    pend = 7'h01;
    settle();
    chk(irq_seen, 9'h020);
    i_ipe_cpu_model.hs(1'b1, 3);
    chk(9'(svc), 9'(IPE_SVC_LOW));
    settle();
    chk(irq_seen, 9'h000);
    pend = 7'h09;
    settle();
    chk(irq_seen, 9'h027);
    i_ipe_cpu_model.hs(1'b1, 0);
    chk(9'(svc), 9'(IPE_SVC_HI_O_LO));
    settle();
    chk(irq_seen, 9'h000);
    i_ipe_cpu_model.hs(1'b0, 0);
    settle();
    chk({irq_seen[6:0], svc}, {7'h27, IPE_SVC_LOW});
    pend = 7'h01;
    i_ipe_cpu_model.hs(1'b0, 0);
    settle();
    chk({irq_seen[6:0], svc}, {7'h20, IPE_SVC_IDLE});
    i_ipe_cpu_model.wr(IPE_PRIO_ADDR, 8'h01);
    settle();
    chk(irq_seen, 9'h021);
    i_ipe_cpu_model.hs(1'b1, 0);
    pend = 7'h7F;
    settle();
    chk({irq_seen[6:0], svc}, {7'h00, IPE_SVC_HIGH});
    i_ipe_cpu_model.hs(1'b0, 0);
    settle();
    chk({irq_seen[6:0], svc}, {7'h21, IPE_SVC_IDLE});
    for (int n = 0; n < 120; n++) begin
      r = $random(seed);
      i_ipe_cpu_model.wr(IPE_PRIO_ADDR, r[7:0]);
      i_ipe_cpu_model.wr(IPE_EMASK_ADDR, r[15:8]);
      prio_e = r[7:0] | 8'h80;
      mask_e = r[15:8] & 8'hBF;
      {gate, pend, en} = r[31:17];
      r = $random(seed);
      flags = r[8:0] & r[17:9];
      ext_hi = r[25:18];
      settle();
      chk(irq_seen, exp_irq());
      i_ipe_cpu_model.rd(IPE_EMASK_ADDR, d, v);
      chk({v, d}, {1'b1, mask_e});
    end
    tally_and_finish();
  end
endmodule : tb_top
